// [cpfp_packer.sv]
`timescale 1ns/1ps
`default_nettype none
// Operation
// [RULE_01] raw mode: 12 bits per pixel, two pixels in each three bytes
// [RULE_02] raw values pass unmodified, the pixel's own filter color sample
// [RULE_03] even rows blue/green, odd rows green/red, by pixel index parity
// [RULE_04] byte one is first pixel bits 11..4, byte three second's
// [RULE_05] middle byte: second pixel low nibble high, first pixel's low
// [RULE_06] raw values are unsigned 12-bit, 0x000 to 0xfff
// [RULE_07] each row starts its first byte with its first pixel, ends likewise
// [RULE_08] rgb mode: 8 bits each of red, green, blue from demosaiced data
// [RULE_09] rgb mode: three bytes per pixel, red then green then blue
// [RULE_10] rgb bytes are unsigned 8-bit, 0x00 to 0xff
// [RULE_11] raw mode assumes an even pixel count per row
// [RULE_12] format select takes effect only at a frame boundary
module cpfp_packer
  import cpfp_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic              fmt_sel,
  input  wire logic              in_valid,
  output logic                   in_ready,
  input  wire logic              in_sof,
  input  wire logic              in_eol,
  input  wire logic [RAW_W-1:0]  in_raw,
  input  wire logic [CH_W-1:0]   in_red,
  input  wire logic [CH_W-1:0]   in_green,
  input  wire logic [CH_W-1:0]   in_blue,
  output cpfp_mode_e             cur_mode,
  output logic                   out_valid,
  input  wire logic              out_ready,
  output logic [CH_W-1:0]        out_data,
  output cpfp_color_e            out_color,
  output logic                   out_sol,
  output logic                   out_eol
);

  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  typedef struct packed {
    cpfp_mode_e       mode;
    logic             row_odd;
    logic             col_odd;
    logic             row_start;
    logic [RAW_W-1:0] hold_pix;
    logic             hold_sol;
  } cpfp_pack_s;

  cpfp_pack_s st_reg;
  cpfp_pack_s st_next;

  logic                             word_valid;
  logic                             word_ready;
  logic [GROUP_BYTES-1:0][CH_W-1:0] word_bytes;
  cpfp_color_e [GROUP_BYTES-1:0]    word_colors;
  logic                             word_sol;
  logic                             word_eol;
  logic                             in_fire;
  logic                             absorb;
  cpfp_mode_e                       mode_eff;
  logic                             row_eff;
  logic                             col_eff;
  logic                             start_eff;

  function automatic cpfp_color_e mosaic_color(input logic row_odd,
                                               input logic col_odd);
    if (!row_odd) begin
      mosaic_color = col_odd ? color_green : color_blue;
    end else begin
      mosaic_color = col_odd ? color_red : color_green;
    end
  endfunction

  // -----------------------------------------------------------------
  // frame position, mode latch and handshake
  // -----------------------------------------------------------------
  // a start-of-frame pixel sees the new mode itself; mid-frame
  // changes on fmt_sel are ignored until the next frame start
  assign mode_eff  = (in_valid && in_sof) ?                     // [RULE_12]
                     (fmt_sel ? rgb_24bit_packed_mode
                              : raw_mosaic_12bit_packed_mode)
                     : st_reg.mode;
  assign row_eff   = in_sof ? 1'b0 : st_reg.row_odd;
  assign col_eff   = in_sof ? 1'b0 : st_reg.col_odd;
  assign start_eff = in_sof | st_reg.row_start;

  // the first pixel of each raw pair is parked, so it never waits
  assign absorb   = (mode_eff == raw_mosaic_12bit_packed_mode) &&
                    !col_eff;
  assign in_ready = absorb ? 1'b1 : word_ready;
  assign in_fire  = in_valid && in_ready;
  assign word_valid = in_valid && !absorb;
  assign cur_mode = st_reg.mode;

  // -----------------------------------------------------------------
  // group assembly
  // -----------------------------------------------------------------
  always_comb begin
    word_bytes  = '0;
    word_colors = '{color_full, color_full, color_full};
    word_sol    = 1'b0;
    word_eol    = in_eol;
    if (mode_eff == raw_mosaic_12bit_packed_mode) begin
      // raw samples pass untouched; full 12-bit range is legal
      word_bytes[0] = st_reg.hold_pix[RAW_HI_MSB:RAW_HI_LSB]; // [RULE_04]
      word_bytes[1] = {in_raw[RAW_LO_MSB:RAW_LO_LSB],
                       st_reg.hold_pix[RAW_LO_MSB:RAW_LO_LSB]}; // [RULE_05]
      word_bytes[2] = in_raw[RAW_HI_MSB:RAW_HI_LSB];  // [RULE_02] [RULE_06]
      word_colors[0] = mosaic_color(row_eff, 1'b0);         // [RULE_03]
      word_colors[1] = mosaic_color(row_eff, 1'b1);
      word_colors[2] = mosaic_color(row_eff, 1'b1);
      word_sol       = st_reg.hold_sol;                     // [RULE_07]
    end else begin
      word_bytes[0] = in_red;                     // [RULE_08] [RULE_09]
      word_bytes[1] = in_green;                             // [RULE_10]
      word_bytes[2] = in_blue;
      word_sol      = start_eff;                            // [RULE_07]
    end
  end

  always_comb begin
    st_next = st_reg;
    if (in_fire) begin
      st_next.mode      = mode_eff;
      st_next.row_odd   = row_eff;
      st_next.row_start = 1'b0;
      st_next.col_odd   = !col_eff;                         // [RULE_01]
      if (absorb) begin
        st_next.hold_pix = in_raw;
        st_next.hold_sol = start_eff;
      end
      if (in_eol) begin
        // a row is taken to end on an odd pixel in raw mode; an odd
        // count would leave its last pixel parked and lost
        st_next.col_odd   = 1'b0;                           // [RULE_11]
        st_next.row_odd   = !row_eff;                       // [RULE_03]
        st_next.row_start = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_reg           <= '0;
      st_reg.mode      <= raw_mosaic_12bit_packed_mode;
      st_reg.row_start <= 1'b1;
      st_reg.hold_pix  <= RAW_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // -----------------------------------------------------------------
  // byte output
  // -----------------------------------------------------------------
  cpfp_byte_serializer u_ser (
    .clk         (clk),
    .reset       (reset),
    .word_valid  (word_valid),
    .word_ready  (word_ready),
    .word_bytes  (word_bytes),
    .word_colors (word_colors),
    .word_sol    (word_sol),
    .word_eol    (word_eol),
    .out_valid   (out_valid),
    .out_ready   (out_ready),
    .out_data    (out_data),
    .out_color   (out_color),
    .out_sol     (out_sol),
    .out_eol     (out_eol)
  );

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  logic word_fire;
  assign word_fire = word_valid && word_ready;

  property p_raw_pair;
    @(posedge clk) disable iff (reset)
      (in_fire && mode_eff == raw_mosaic_12bit_packed_mode)
      |-> (word_fire == col_eff);
  endproperty
  a_raw_pair: assert property (p_raw_pair) // [RULE_01]
    else $error("raw group not formed on second pixel");

  property p_raw_unmodified;
    @(posedge clk) disable iff (reset)
      (word_fire && mode_eff == raw_mosaic_12bit_packed_mode)
      |-> (word_bytes[2] == in_raw[RAW_HI_MSB:RAW_HI_LSB]);
  endproperty
  a_raw_unmodified: assert property (p_raw_unmodified) // [RULE_02]
    else $error("second pixel high bits altered");

  property p_color_order;
    @(posedge clk) disable iff (reset)
      (word_fire && mode_eff == raw_mosaic_12bit_packed_mode)
      |-> (word_colors[0] == (row_eff ? color_green : color_blue)) &&
          (word_colors[2] == (row_eff ? color_red : color_green));
  endproperty
  a_color_order: assert property (p_color_order) // [RULE_03]
    else $error("mosaic color order wrong");

  property p_first_high;
    @(posedge clk) disable iff (reset)
      (word_fire && mode_eff == raw_mosaic_12bit_packed_mode)
      |-> (word_bytes[0] == st_reg.hold_pix[RAW_HI_MSB:RAW_HI_LSB]);
  endproperty
  a_first_high: assert property (p_first_high) // [RULE_04]
    else $error("first byte not first pixel high bits");

  property p_mid_nibbles;
    @(posedge clk) disable iff (reset)
      (in_fire && absorb) ##1 (in_fire && !absorb && !in_sof)
      |-> (word_bytes[1] == {in_raw[RAW_LO_MSB:RAW_LO_LSB],
                             $past(in_raw[RAW_LO_MSB:RAW_LO_LSB], 1)});
  endproperty
  a_mid_nibbles: assert property (p_mid_nibbles) // [RULE_05]
    else $error("middle byte nibbles misplaced");

  property p_row_restart;
    @(posedge clk) disable iff (reset)
      (in_fire && in_eol) |=> (!st_reg.col_odd && st_reg.row_start);
  endproperty
  a_row_restart: assert property (p_row_restart) // [RULE_07]
    else $error("row did not restart at first pixel");

  property p_rgb_order;
    @(posedge clk) disable iff (reset)
      (word_fire && mode_eff == rgb_24bit_packed_mode)
      |-> (word_bytes == {in_blue, in_green, in_red});
  endproperty
  a_rgb_order: assert property (p_rgb_order) // [RULE_09]
    else $error("rgb bytes not red green blue");

  property p_mode_at_frame;
    @(posedge clk) disable iff (reset)
      (st_reg.mode != $past(st_reg.mode, 1))
      |-> $past(in_fire && in_sof, 1);
  endproperty
  a_mode_at_frame: assert property (p_mode_at_frame) // [RULE_12]
    else $error("format changed inside a frame");

endmodule
`default_nettype wire

// [cpfp_pkg.sv]
package cpfp_pkg;

  // -----------------------------------------------------------------
  // widths and positions
  // -----------------------------------------------------------------
  localparam int RAW_W        = 12;
  localparam int CH_W         = 8;
  localparam int RAW_HI_MSB   = 11;
  localparam int RAW_HI_LSB   = 4;
  localparam int RAW_LO_MSB   = 3;
  localparam int RAW_LO_LSB   = 0;
  localparam int GROUP_BYTES  = 3;
  localparam logic [1:0] LAST_BYTE_IDX = 2'h2;

  // -----------------------------------------------------------------
  // reset values
  // -----------------------------------------------------------------
  localparam logic [RAW_W-1:0] RAW_RESET = 12'h000;
  localparam logic [CH_W-1:0]  BYTE_RESET = 8'h00;

  // -----------------------------------------------------------------
  // enumerations
  // -----------------------------------------------------------------
  typedef enum logic {
    raw_mosaic_12bit_packed_mode,
    rgb_24bit_packed_mode
  } cpfp_mode_e;

  typedef enum logic [1:0] {
    color_blue,
    color_green,
    color_red,
    color_full
  } cpfp_color_e;

endpackage

// [cpfp_byte_serializer.sv]
`timescale 1ns/1ps
`default_nettype none
module cpfp_byte_serializer
  import cpfp_pkg::*;
(
  input  wire logic                     clk,
  input  wire logic                     reset,
  input  wire logic                     word_valid,
  output logic                          word_ready,
  input  wire logic [GROUP_BYTES-1:0][CH_W-1:0] word_bytes,
  input  wire cpfp_color_e [GROUP_BYTES-1:0]    word_colors,
  input  wire logic                     word_sol,
  input  wire logic                     word_eol,
  output logic                          out_valid,
  input  wire logic                     out_ready,
  output logic [CH_W-1:0]               out_data,
  output cpfp_color_e                   out_color,
  output logic                          out_sol,
  output logic                          out_eol
);

  typedef struct packed {
    logic [GROUP_BYTES-1:0][CH_W-1:0] bytes;
    cpfp_color_e [GROUP_BYTES-1:0]    colors;
    logic [1:0]                       idx;
    logic                             busy;
    logic                             sol;
    logic                             eol;
  } cpfp_ser_s;

  cpfp_ser_s st_reg;
  cpfp_ser_s st_next;

  // one bubble between groups keeps the ready path free of out_ready
  assign word_ready = !st_reg.busy;
  assign out_valid  = st_reg.busy;
  assign out_data   = st_reg.bytes[st_reg.idx];
  assign out_color  = st_reg.colors[st_reg.idx];
  assign out_sol    = st_reg.busy && st_reg.sol && (st_reg.idx == 2'h0);
  assign out_eol    = st_reg.busy && st_reg.eol &&
                      (st_reg.idx == LAST_BYTE_IDX);

  always_comb begin
    st_next = st_reg;
    if (st_reg.busy) begin
      if (out_ready) begin
        if (st_reg.idx == LAST_BYTE_IDX) begin
          st_next.busy = 1'b0;
          st_next.idx  = 2'h0;
        end else begin
          st_next.idx = st_reg.idx + 2'h1;
        end
      end
    end else if (word_valid) begin
      st_next.bytes  = word_bytes;
      st_next.colors = word_colors;
      st_next.sol    = word_sol;
      st_next.eol    = word_eol;
      st_next.idx    = 2'h0;
      st_next.busy   = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // a byte that the host has not taken must not slip or change
  property p_hold_stable;
    @(posedge clk) disable iff (reset)
      (out_valid && !out_ready)
      |=> (out_valid && $stable(out_data) && $stable(out_color));
  endproperty
  a_hold_stable: assert property (p_hold_stable) // [RULE_07]
    else $error("byte changed before the host took it");

endmodule
`default_nettype wire

// [cpfp_host_sink.sv]
`timescale 1ns/1ps
`default_nettype none
module cpfp_host_sink
  import cpfp_pkg::*;
(
  input  wire logic            clk,
  input  wire logic            reset,
  input  wire logic            slow,
  input  wire logic            out_valid,
  output logic                 out_ready,
  input  wire logic [CH_W-1:0] out_data,
  input  wire cpfp_color_e     out_color,
  input  wire logic            out_sol,
  input  wire logic            out_eol
);
  // -----------------------------------------------------------------
  // image buffer: every accepted byte with its tags
  // -----------------------------------------------------------------
  logic [11:0] got [$];
  logic [1:0]  phase;

  initial begin
    phase     = 2'h0;
    out_ready = 1'b1;
  end

  // slow host takes one byte in four, so groups stall mid-way
  always @(negedge clk) begin
    phase     <= phase + 2'h1;
    out_ready <= !slow || (phase == 2'h3);
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      got.delete();
    end else if (out_valid === 1'b1 && out_ready) begin
      got.push_back({out_sol, out_eol, out_color, out_data});
    end
  end
endmodule
`default_nettype wire

// [cpfp_packer_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module cpfp_packer_tb_top
  import cpfp_pkg::*;
;
  `define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
    errors++; $display("BAD %0t got %h exp %h", $time, g, e); end end

  typedef struct {
    logic             fmt;
    logic [RAW_W-1:0] a;
    logic [RAW_W-1:0] b;
    logic [CH_W-1:0]  e0;
    logic [CH_W-1:0]  e1;
    logic [CH_W-1:0]  e2;
  } cpfp_row_s;

  logic             clk, reset, fmt_sel, in_valid, in_ready, in_sof, in_eol;
  logic [RAW_W-1:0] in_raw, p0, p1;
  logic [CH_W-1:0]  in_red, in_green, in_blue, out_data;
  cpfp_mode_e       cur_mode;
  cpfp_color_e      out_color;
  logic             out_valid, out_ready, out_sol, out_eol, slow;
  logic [11:0]      exp_q [$];
  int               errors, samples_checked, cycles;
  cpfp_row_s        rows [6];

  cpfp_packer i_dut (.clk(clk), .reset(reset), .fmt_sel(fmt_sel),
    .in_valid(in_valid), .in_ready(in_ready), .in_sof(in_sof),
    .in_eol(in_eol), .in_raw(in_raw), .in_red(in_red),
    .in_green(in_green), .in_blue(in_blue), .cur_mode(cur_mode),
    .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
    .out_color(out_color), .out_sol(out_sol), .out_eol(out_eol));

  cpfp_host_sink i_sink (.clk(clk), .reset(reset), .slow(slow),
    .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
    .out_color(out_color), .out_sol(out_sol), .out_eol(out_eol));

  // -----------------------------------------------------------------
  // clock, timeout and verdict
  // -----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic finish_test();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles > 5000) begin
      errors++;
      finish_test();
    end
  end

  // -----------------------------------------------------------------
  // drivers and expectations
  // -----------------------------------------------------------------
  // pixel held from a falling edge until a rising edge sees in_ready
  task automatic send_pix(input logic f, s, e, input logic [11:0] r,
                          input logic [7:0] cr, cg, cb);
    int n;
    @(negedge clk);
    {fmt_sel, in_sof, in_eol, in_raw} = {f, s, e, r};
    {in_red, in_green, in_blue, in_valid} = {cr, cg, cb, 1'b1};
    n = 0;
    #1;
    while (in_ready !== 1'b1 && n < 100) begin
      @(negedge clk);
      #1;
      n++;
    end
    if (n >= 100) begin
      errors++;
      $display("BAD %0t pixel never accepted", $time);
    end
    @(posedge clk);
  endtask

  task automatic idle();
    @(negedge clk);
    in_valid = 1'b0;
  endtask

  task automatic push_exp(input logic [7:0] d, input cpfp_color_e c,
                          input logic s, e);
    exp_q.push_back({s, e, c, d});
  endtask

  task automatic exp_pair(input logic [11:0] a, b, input logic odd, s, e);
    cpfp_color_e c0, c1;
    c0 = odd ? color_green : color_blue;
    c1 = odd ? color_red : color_green;
    push_exp(a[11:4], c0, s, 1'b0);
    push_exp({b[3:0], a[3:0]}, c1, 1'b0, 1'b0);
    push_exp(b[11:4], c1, 1'b0, e);
  endtask

  task automatic drain_check();
    int n;
    n = 0;
    while (i_sink.got.size() < exp_q.size() && n < 300) begin
      @(posedge clk);
      n++;
    end
    repeat (8) @(posedge clk);
    `CHK(i_sink.got.size(), exp_q.size())
    foreach (exp_q[i]) begin
      if (i < i_sink.got.size()) begin
        `CHK(i_sink.got[i], exp_q[i])
      end
    end
    @(negedge clk);
    exp_q.delete();
    i_sink.got.delete();
  endtask

  // -----------------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------------
  initial begin
    {reset, fmt_sel, in_valid, in_sof, in_eol, slow} = 6'h20;
    {in_raw, in_red, in_green, in_blue} = 36'h0;
    errors = 0;
    samples_checked = 0;
    cycles = 0;
    rows = '{'{1'b0, 12'h000, 12'hfff, 8'h00, 8'hf0, 8'hff},
             '{1'b1, 12'h5a5, 12'h000, 8'hff, 8'h00, 8'h80},
             '{1'b0, 12'hfff, 12'h000, 8'hff, 8'h0f, 8'h00},
             '{1'b0, 12'habc, 12'h123, 8'hab, 8'h3c, 8'h12},
             '{1'b1, 12'h3c3, 12'h000, 8'h01, 8'hfe, 8'h7f},
             '{1'b1, 12'h000, 12'hfff, 8'h00, 8'h00, 8'h00}};
    repeat (4) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    // one-row frames; in raw rows fmt_sel flips on the second pixel and must be ignored
    foreach (rows[i]) begin
      if (rows[i].fmt) begin
        send_pix(1'b1, 1'b1, 1'b1, rows[i].a, rows[i].e0, rows[i].e1,
                 rows[i].e2);
        push_exp(rows[i].e0, color_full, 1'b1, 1'b0);
        push_exp(rows[i].e1, color_full, 1'b0, 1'b0);
        push_exp(rows[i].e2, color_full, 1'b0, 1'b1);
      end else begin
        send_pix(1'b0, 1'b1, 1'b0, rows[i].a, 8'h11, 8'h22, 8'h33);
        send_pix(1'b1, 1'b0, 1'b1, rows[i].b, 8'h44, 8'h55, 8'h66);
        push_exp(rows[i].e0, color_blue, 1'b1, 1'b0);
        push_exp(rows[i].e1, color_green, 1'b0, 1'b0);
        push_exp(rows[i].e2, color_green, 1'b0, 1'b1);
      end
      idle();
      `CHK(cur_mode, cpfp_mode_e'(rows[i].fmt))
      drain_check();
    end
    // two rows of four, back to back, against a stalling host
    slow = 1'b1;
    for (int r = 0; r < 2; r++) begin
      for (int k = 0; k < 4; k += 2) begin
        p0 = 12'((r * 4 + k) * 12'h135 + 12'h00f);
        p1 = 12'((r * 4 + k + 1) * 12'h135 + 12'h00f);
        send_pix(1'b0, r == 0 && k == 0, 1'b0, p0, 8'h0, 8'h0, 8'h0);
        send_pix(1'b1, 1'b0, k == 2, p1, 8'h0, 8'h0, 8'h0);
        exp_pair(p0, p1, r[0], k == 0, k == 2);
      end
    end
    idle();
    `CHK(cur_mode, raw_mosaic_12bit_packed_mode)
    drain_check();
    slow = 1'b0;
    // reset while an rgb pixel is still leaving
    send_pix(1'b1, 1'b1, 1'b1, 12'h000, 8'h12, 8'h34, 8'h56);
    idle();
    @(negedge clk);
    reset = 1'b1;
    repeat (2) @(negedge clk);
    `CHK(out_valid, 1'b0)
    `CHK(in_ready, 1'b1)
    `CHK(cur_mode, raw_mosaic_12bit_packed_mode)
    reset = 1'b0;
    // a lone raw pixel in a row is dropped; the rgb frame after it must
    // come out alone and whole
    send_pix(1'b0, 1'b1, 1'b1, 12'h000, 8'h0, 8'h0, 8'h0);
    send_pix(1'b1, 1'b1, 1'b1, 12'h000, 8'h9a, 8'hbc, 8'hde);
    push_exp(8'h9a, color_full, 1'b1, 1'b0);
    push_exp(8'hbc, color_full, 1'b0, 1'b0);
    push_exp(8'hde, color_full, 1'b0, 1'b1);
    idle();
    `CHK(cur_mode, rgb_24bit_packed_mode)
    drain_check();
    finish_test();
  end
endmodule
`default_nettype wire
